// file: rtl/sct_pkg.sv
package sct_pkg;
  // ==========================================================================
  // register byte offsets (32-bit aligned words)
  localparam logic [7:0]  OFS_CTRL      = 8'h00;  // counter_run, update_block, filter, polarity, mode bits
  localparam logic [7:0]  OFS_EVGEN     = 8'h04;  // write-only: force_update, channel_soft_event
  localparam logic [7:0]  OFS_STATUS    = 8'h08;  // flags, write 0 to clear
  localparam logic [7:0]  OFS_DIVIDER   = 8'h0c;
  localparam logic [7:0]  OFS_RELOAD    = 8'h10;
  localparam logic [7:0]  OFS_CHVALUE   = 8'h14;
  localparam logic [7:0]  OFS_COUNT     = 8'h18;
  // ==========================================================================
  // control register fields
  localparam int CTL_RUN      = 0;
  localparam int CTL_UPBLK    = 1;
  localparam int CTL_IRQEN    = 2;
  localparam int CTL_OUTEN    = 3;
  localparam int CTL_POL      = 4;
  localparam int CTL_POLC     = 5;
  localparam int CTL_CPEN     = 6;
  localparam int CTL_DIR_LO   = 8;   // channel_direction_sel [9:8]
  localparam int CTL_ACT_LO   = 12;  // compare_action_sel [14:12]
  localparam int CTL_FLT_LO   = 16;  // input_filter_setting [19:16]
  localparam int CTL_EPS_LO   = 20;  // event prescaler [21:20]
  localparam int CTL_WIDTH    = 22;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = '0;
  // event generation / status fields
  localparam int EVG_UPD      = 0;
  localparam int EVG_CHG      = 1;
  localparam int STS_UPD      = 0;
  localparam int STS_CHEV     = 1;
  localparam int STS_OVR      = 9;
  // reset values
  localparam logic [15:0] RELOAD_RESET  = 16'hffff;
  localparam logic [15:0] ZERO16        = 16'h0000;
  // channel source codes
  localparam logic [1:0]  DIR_OUTPUT    = 2'h0;
  localparam logic [1:0]  DIR_OWN_IN    = 2'h1;
  localparam logic [1:0]  DIR_OTHER_IN  = 2'h2;
  localparam logic [1:0]  DIR_TRIGGER   = 2'h3;
  // compare action codes
  localparam logic [2:0]  ACT_HOLD      = 3'h0;
  localparam logic [2:0]  ACT_SET       = 3'h1;
  localparam logic [2:0]  ACT_CLEAR     = 3'h2;
  localparam logic [2:0]  ACT_TOGGLE    = 3'h3;
  localparam logic [2:0]  ACT_FORCE_LO  = 3'h4;
  localparam logic [2:0]  ACT_FORCE_HI  = 3'h5;
  localparam logic [2:0]  ACT_PWM0      = 3'h6;
  localparam logic [2:0]  ACT_PWM1      = 3'h7;
endpackage

// file: rtl/sct_timer.sv
`timescale 1ns/1ps
// Behaviour
// - 16-bit counter counts upward only, on the single timer clock.
// - counting rate is timer clock divided by divider_value plus one.
// - new divider_value waits in a shadow until the next update event.
// - counter runs 0 to reload_limit, wraps to 0, update event on wrap.
// - force_update clears the counter and raises an update event.
// - update_block set suppresses all update events.
// - update event copies preloaded reload and divider into active copies.
// - channel input is synchronised then digitally filtered before edge detection.
// - rising, falling or both edges chosen by polarity and complement bits.
// - capture stores counter, sets event flag, interrupt when enabled.
// - event prescaler turns several detected edges into one capture.
// - capture source is own input, other input or internal trigger.
// - nonzero direction select means input mode; value writes ignored.
// - capture while event flag already set also sets overrun flag.
// - channel_soft_event sets the event flag, interrupt when enabled.
// - on match output_prepare holds, sets, clears or toggles per action.
// - actions 4 and 5 force output_prepare inactive or active.
// - actions 6 and 7 give PWM, period reload_limit plus one, duty channel value.
// - PWM mode 0: value above limit always active, zero always inactive.
// - compare match sets event flag and interrupt when enabled.
// - channel_out_pin follows output_prepare xor polarity bit, gated by output enable.
// - compare_preload_enable picks shadowed or immediate compare value.
module sct_timer
  import sct_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        channel_in_pin,
  input  wire logic        other_channel_in,
  input  wire logic        internal_trigger,
  output logic             channel_out_pin,
  output logic             channel_irq,
  output logic             update_pulse
);
  // ==========================================================================
  // registers
  logic [CTL_WIDTH-1:0] ctrl;
  logic [15:0]          divider_value;     // preload
  logic [15:0]          divider_active;
  logic [15:0]          reload_limit;      // preload
  logic [15:0]          reload_active;
  logic [15:0]          channel_value_reg; // preload / capture result
  logic [15:0]          compare_active;
  logic [15:0]          count;
  logic [15:0]          div_count;
  logic                 upd_flag;
  logic                 channel_event_flag;
  logic                 channel_overrun_flag;
  logic                 output_prepare;
  logic                 in_sync1;
  logic                 in_sync2;
  logic                 filt_prev;
  logic                 filtered;
  logic [3:0]           filt_count;
  logic [1:0]           eps_count;
  logic                 cap_prev;

  // ==========================================================================
  // bus decode; every access finishes in its first access cycle
  wire bus_wr     = psel & penable & pwrite;
  wire wr_ctrl    = bus_wr & (paddr == OFS_CTRL);
  wire wr_evgen   = bus_wr & (paddr == OFS_EVGEN);
  wire wr_status  = bus_wr & (paddr == OFS_STATUS);
  wire wr_div     = bus_wr & (paddr == OFS_DIVIDER);
  wire wr_reload  = bus_wr & (paddr == OFS_RELOAD);
  wire wr_chval   = bus_wr & (paddr == OFS_CHVALUE);
  wire known_addr = (paddr == OFS_CTRL) | (paddr == OFS_EVGEN) | (paddr == OFS_STATUS) |
                    (paddr == OFS_DIVIDER) | (paddr == OFS_RELOAD) | (paddr == OFS_CHVALUE) |
                    (paddr == OFS_COUNT);

  // control field views
  wire       run         = ctrl[CTL_RUN];
  wire       update_block = ctrl[CTL_UPBLK];
  wire [1:0] dir_sel     = ctrl[CTL_DIR_LO +: 2];
  wire [2:0] action      = ctrl[CTL_ACT_LO +: 3];
  wire [3:0] filt_set    = ctrl[CTL_FLT_LO +: 4];
  wire [1:0] eps_set     = ctrl[CTL_EPS_LO +: 2];
  wire       input_mode  = (dir_sel != DIR_OUTPUT);

  // ==========================================================================
  // prescaler and counter timing
  wire force_update = wr_evgen & pwdata[EVG_UPD];
  wire soft_event   = wr_evgen & pwdata[EVG_CHG];
  wire tick         = run & (div_count == divider_active);
  wire wrap         = tick & (count >= reload_active);
  // update_block still lets force_update restart counter and divider
  wire update_ev    = (wrap | force_update) & ~update_block;
  wire [15:0] cmp_now = ctrl[CTL_CPEN] ? compare_active : channel_value_reg;
  wire match        = run & ~input_mode & (count == cmp_now);

  // ==========================================================================
  // input stage: sync, filter, edge, source, prescale
  wire filt_hit  = (filt_count >= filt_set);
  wire rise      = filtered & ~filt_prev;
  wire fall      = ~filtered & filt_prev;
  // complement bit set selects both edges, whatever the polarity bit
  wire own_edge  = ctrl[CTL_POLC] ? (rise | fall) : (ctrl[CTL_POL] ? fall : rise);
  wire src_lvl   = (dir_sel == DIR_OTHER_IN) ? other_channel_in : internal_trigger;
  wire src_edge  = (dir_sel == DIR_OWN_IN) ? own_edge : (src_lvl & ~cap_prev);
  wire eps_done  = (eps_count == eps_set);
  wire capture   = input_mode & src_edge & eps_done;
  wire ch_event  = capture | (match & ~input_mode) | soft_event;

  // ==========================================================================
  // compare output logic
  wire pwm0_lvl  = (count < cmp_now);
  logic next_prepare;
  always_comb begin
    next_prepare = output_prepare;
    unique case (action)
      ACT_HOLD:     next_prepare = output_prepare;
      ACT_SET:      if (match) next_prepare = 1'b1;
      ACT_CLEAR:    if (match) next_prepare = 1'b0;
      ACT_TOGGLE:   if (match) next_prepare = ~output_prepare;
      ACT_FORCE_LO: next_prepare = 1'b0;
      ACT_FORCE_HI: next_prepare = 1'b1;
      ACT_PWM0:     next_prepare = pwm0_lvl;
      ACT_PWM1:     next_prepare = ~pwm0_lvl;
    endcase
    if (input_mode) begin
      next_prepare = 1'b0;
    end
  end

  // ==========================================================================
  // register writes and shadows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl           <= CTL_RESET;
      divider_value  <= ZERO16;
      reload_limit   <= RELOAD_RESET;
      divider_active <= ZERO16;
      reload_active  <= RELOAD_RESET;
    end else begin
      if (wr_ctrl) ctrl <= pwdata[CTL_WIDTH-1:0];
      if (wr_div) divider_value <= pwdata[15:0];
      if (wr_reload) reload_limit <= pwdata[15:0];
      if (update_ev) begin
        divider_active <= wr_div ? pwdata[15:0] : divider_value;
        reload_active  <= wr_reload ? pwdata[15:0] : reload_limit;
      end
    end
  end

  // channel value: software write in output mode, capture in input mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_value_reg <= ZERO16;
      compare_active    <= ZERO16;
    end else begin
      if (capture) channel_value_reg <= count;
      else if (wr_chval && !input_mode) channel_value_reg <= pwdata[15:0];
      if (update_ev) compare_active <= channel_value_reg;
    end
  end

  // ==========================================================================
  // divider and counter; force_update restarts both even while blocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= ZERO16;
      count     <= ZERO16;
    end else if (force_update) begin
      div_count <= ZERO16;
      count     <= ZERO16;
    end else if (run) begin
      div_count <= tick ? ZERO16 : div_count + 16'h0001;
      if (wrap) count <= ZERO16;
      else if (tick) count <= count + 16'h0001;
    end
  end

  // ==========================================================================
  // flags: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upd_flag             <= 1'b0;
      channel_event_flag   <= 1'b0;
      channel_overrun_flag <= 1'b0;
    end else begin
      upd_flag <= update_ev | (upd_flag & ~(wr_status & ~pwdata[STS_UPD]));
      channel_event_flag <= ch_event |
                            (channel_event_flag & ~(wr_status & ~pwdata[STS_CHEV]));
      channel_overrun_flag <= (capture & channel_event_flag) |
                              (channel_overrun_flag & ~(wr_status & ~pwdata[STS_OVR]));
    end
  end

  // ==========================================================================
  // input synchroniser, filter and prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sync1   <= 1'b0;
      in_sync2   <= 1'b0;
      filtered   <= 1'b0;
      filt_prev  <= 1'b0;
      filt_count <= 4'h0;
      eps_count  <= 2'h0;
      cap_prev   <= 1'b0;
    end else begin
      in_sync1  <= channel_in_pin;
      in_sync2  <= in_sync1;
      filt_prev <= filtered;
      cap_prev  <= src_lvl;
      // sample must differ for filt_set+1 clocks before it is accepted
      if (in_sync2 == filtered) filt_count <= 4'h0;
      else if (filt_hit) begin
        filtered   <= in_sync2;
        filt_count <= 4'h0;
      end else filt_count <= filt_count + 4'h1;
      if (!input_mode) eps_count <= 2'h0;
      else if (src_edge) eps_count <= eps_done ? 2'h0 : eps_count + 2'h1;
    end
  end

  // ==========================================================================
  // outputs and read data
  wire pin_lvl = ctrl[CTL_OUTEN] & (output_prepare ^ ctrl[CTL_POL]);
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:    next_rdata = {{(32-CTL_WIDTH){1'b0}}, ctrl};
      OFS_STATUS:  next_rdata = {22'h000000, channel_overrun_flag, 7'h00, channel_event_flag, upd_flag};
      OFS_DIVIDER: next_rdata = {16'h0000, divider_value};
      OFS_RELOAD:  next_rdata = {16'h0000, reload_limit};
      OFS_CHVALUE: next_rdata = {16'h0000, channel_value_reg};
      OFS_COUNT:   next_rdata = {16'h0000, count};
      default:     next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_prepare  <= 1'b0;
      channel_out_pin <= 1'b0;
      channel_irq     <= 1'b0;
      update_pulse    <= 1'b0;
      pready          <= 1'b0;
      prdata          <= 32'h0000_0000;
      pslverr         <= 1'b0;
    end else begin
      output_prepare  <= next_prepare;
      channel_out_pin <= pin_lvl;
      channel_irq     <= ctrl[CTL_IRQEN] & channel_event_flag;
      update_pulse    <= update_ev;
      // ready in the cycle after setup, so access phase is one cycle
      pready          <= psel & ~penable;
      prdata          <= next_rdata;
      pslverr         <= psel & ~penable & ~known_addr;
    end
  end

  // ==========================================================================
  // checks
  a_wrap_zero: assert property (
    @(posedge pclk) disable iff (!presetn) wrap && !force_update |=> count == 16'h0000)
    else $error("counter did not wrap");
  a_force_clear: assert property (
    @(posedge pclk) disable iff (!presetn) force_update |=> count == 16'h0000 && div_count == 16'h0000)
    else $error("force update ignored");
  a_block_update: assert property (
    @(posedge pclk) disable iff (!presetn) update_block |-> !update_ev)
    else $error("update while blocked");
  a_shadow_load: assert property (
    @(posedge pclk) disable iff (!presetn) update_ev && !wr_reload |=> reload_active == $past(reload_limit))
    else $error("reload not loaded");
  a_divider_hold: assert property (
    @(posedge pclk) disable iff (!presetn) !update_ev |=> divider_active == $past(divider_active))
    else $error("divider changed early");
  a_capture_store: assert property (
    @(posedge pclk) disable iff (!presetn) capture |=> channel_value_reg == $past(count) && channel_event_flag)
    else $error("capture lost");
  a_overrun_set: assert property (
    @(posedge pclk) disable iff (!presetn) capture && channel_event_flag |=> channel_overrun_flag)
    else $error("overrun missed");
  a_input_wrprot: assert property (
    @(posedge pclk) disable iff (!presetn) wr_chval && input_mode && !capture |=> $stable(channel_value_reg))
    else $error("input mode write");
  a_force_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    action == ACT_FORCE_HI && !input_mode ##1 action == ACT_FORCE_HI |-> output_prepare)
    else $error("force active failed");
  a_pin_follow: assert property (
    @(posedge pclk) disable iff (!presetn) ##1 ctrl[CTL_OUTEN] && $stable(ctrl) |->
    ##1 channel_out_pin == ($past(output_prepare) ^ $past(ctrl[CTL_POL])))
    else $error("pin mismatch");
  // counter moves only on a divided tick or force_update, one step at a time except at wrap
  a_count_step: assert property (
    @(posedge pclk) disable iff (!presetn) tick && !wrap && !force_update |=> count == $past(count) + 16'h0001)
    else $error("counter step wrong");
  a_count_hold: assert property (
    @(posedge pclk) disable iff (!presetn) !tick && !force_update |=> $stable(count))
    else $error("counter moved without tick");
  a_tick_restart: assert property (
    @(posedge pclk) disable iff (!presetn) tick && !force_update |=> div_count == 16'h0000)
    else $error("divider did not restart");
  a_update_pulse: assert property (
    @(posedge pclk) disable iff (!presetn) update_ev |=> update_pulse)
    else $error("update pulse missing");
  a_force_event: assert property (
    @(posedge pclk) disable iff (!presetn) force_update && !update_block |=> update_pulse)
    else $error("forced update missing");
  a_filter_pass: assert property (
    @(posedge pclk) disable iff (!presetn) filt_set == 4'h0 && in_sync2 != filtered |=> filtered == $past(in_sync2))
    else $error("filter did not pass");
  a_rise_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    dir_sel == DIR_OWN_IN && !ctrl[CTL_POLC] && !ctrl[CTL_POL] && rise && eps_done |-> capture)
    else $error("rising edge missed");
  a_prescale_skip: assert property (
    @(posedge pclk) disable iff (!presetn) !eps_done |-> !capture)
    else $error("capture before prescale count");
  a_other_source: assert property (
    @(posedge pclk) disable iff (!presetn)
    dir_sel == DIR_OTHER_IN && other_channel_in && !cap_prev && eps_done |-> capture)
    else $error("other source edge missed");
  a_soft_flag: assert property (
    @(posedge pclk) disable iff (!presetn) soft_event |=> channel_event_flag)
    else $error("soft event lost");
  a_match_set: assert property (
    @(posedge pclk) disable iff (!presetn) action == ACT_SET && match |=> output_prepare)
    else $error("set on match failed");
  a_match_clear: assert property (
    @(posedge pclk) disable iff (!presetn) action == ACT_CLEAR && match |=> !output_prepare)
    else $error("clear on match failed");
  // compare above the limit keeps mode 0 active for the whole period
  a_pwm_full: assert property (
    @(posedge pclk) disable iff (!presetn)
    action == ACT_PWM0 && !input_mode && cmp_now > reload_active && count <= reload_active |=> output_prepare)
    else $error("pwm not always active");
  a_pwm_inverse: assert property (
    @(posedge pclk) disable iff (!presetn)
    action == ACT_PWM1 && !input_mode |=> output_prepare == !($past(count) < $past(cmp_now)))
    else $error("pwm mode 1 level wrong");
  a_compare_flag: assert property (
    @(posedge pclk) disable iff (!presetn) match |=> channel_event_flag)
    else $error("compare flag missing");
  a_preload_hold: assert property (
    @(posedge pclk) disable iff (!presetn) !update_ev |=> $stable(compare_active))
    else $error("compare shadow moved early");
endmodule

// file: tb/sct_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// far side: capture sources and the compare output pin
module sct_pin_model (
  input  wire logic pclk,
  input  wire logic channel_out_pin,
  output logic      channel_in_pin,
  output logic      other_channel_in,
  output logic      internal_trigger
);
  // sources idle low and hold their level between edges, like a real driver
  initial begin
    channel_in_pin   = 1'b0;
    other_channel_in = 1'b0;
    internal_trigger = 1'b0;
  end
  // src 0 own pin, 1 other channel, 2 internal trigger; moves just after an edge
  task automatic level(input int src, input logic v);
    @(posedge pclk);
    case (src)
      0: channel_in_pin <= v;
      1: other_channel_in <= v;
      default: internal_trigger <= v;
    endcase
  endtask
  // high for width cycles, so a short width probes the filter
  task automatic pulse(input int src, input int width);
    level(src, 1'b1);
    repeat (width - 1) @(posedge pclk);
    level(src, 1'b0);
  endtask
  // window is a whole number of periods, so phase does not matter
  task automatic high_count(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge pclk);
      if (channel_out_pin === 1'b1) cnt++;
    end
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import sct_pkg::*;
;
  localparam logic [7:0] RUN = 8'h01, UBLK = 8'h02, IEN = 8'h04, OEN = 8'h08;
  localparam logic [7:0] POL = 8'h10, PCOMP = 8'h20, CPEN = 8'h40, RO = 8'h09;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        channel_in_pin, other_channel_in, internal_trigger;
  logic        channel_out_pin, channel_irq, update_pulse, serr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv, cval;
  int          num_errors = 0, total_checks = 0, upd_seen = 0, n, m;
  sct_timer u_sct_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .channel_in_pin(channel_in_pin), .other_channel_in(other_channel_in), .internal_trigger(internal_trigger),
    .channel_out_pin(channel_out_pin), .channel_irq(channel_irq), .update_pulse(update_pulse));
  sct_pin_model u_sct_pin_model (.pclk(pclk), .channel_out_pin(channel_out_pin), .channel_in_pin(channel_in_pin),
    .other_channel_in(other_channel_in), .internal_trigger(internal_trigger));
  // ==========================================================
  // clock, update pulse tally, watchdog
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (update_pulse === 1'b1) upd_seen++;
  // whole run needs about 1200 cycles; this is well beyond it
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    conclude();
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] cfg(input logic [2:0] act, input logic [1:0] dir, input logic [3:0] flt,
                                      input logic [1:0] eps, input logic [7:0] bits);
    cfg = {10'h000, eps, flt, 1'b0, act, 2'b00, dir, bits};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic to_pulse(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (update_pulse !== 1'b1);
  endtask
  task automatic omode(input logic [2:0] act, input logic [7:0] bits, input int exp);
    wr(OFS_CTRL, cfg(act, DIR_OUTPUT, 4'h0, 2'h0, bits));
    cyc(22);
    u_sct_pin_model.high_count(20, m);
    chk(m, exp);
  endtask
  task automatic cap(input logic [31:0] c, input int src, input int width, input logic [31:0] exp);
    wr(OFS_CTRL, c);
    wr(OFS_STATUS, 32'h0);
    u_sct_pin_model.pulse(src, width);
    cyc(8);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rv & 32'h202, exp);
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_RELOAD, {16'h0000, RELOAD_RESET});
    rdc(OFS_DIVIDER, 32'h0);
    rdc(OFS_COUNT, 32'h0);
    rdc(8'h40, 32'h0);
    chk({31'h0, serr}, 32'h1);
    // period is (reload+1)*(divider+1); a new divider waits for the update
    wr(OFS_RELOAD, 32'h4);
    wr(OFS_DIVIDER, 32'h1);
    wr(OFS_EVGEN, 32'h1);
    wr(OFS_CTRL, cfg(ACT_HOLD, DIR_OUTPUT, 4'h0, 2'h0, RUN));
    to_pulse(n);
    to_pulse(n);
    chk(n, 10);
    wr(OFS_DIVIDER, 32'h3);
    to_pulse(n);
    chk(n < 10, 1);
    to_pulse(n);
    chk(n, 20);
    wr(OFS_CTRL, cfg(ACT_HOLD, DIR_OUTPUT, 4'h0, 2'h0, RUN | UBLK));
    n = upd_seen;
    cyc(50);
    chk(upd_seen - n, 0);
    wr(OFS_CTRL, 32'h0);
    n = upd_seen;
    wr(OFS_EVGEN, 32'h1);
    cyc(3);
    chk(upd_seen - n, 1);
    rdc(OFS_COUNT, 32'h0);
    // compare output modes, period 10, match at 3
    wr(OFS_RELOAD, 32'h9);
    wr(OFS_DIVIDER, 32'h0);
    wr(OFS_CHVALUE, 32'h3);
    wr(OFS_EVGEN, 32'h1);
    omode(ACT_FORCE_HI, RO, 20);
    omode(ACT_FORCE_HI, RO | POL, 0);
    omode(ACT_FORCE_HI, RUN, 0);
    omode(ACT_FORCE_LO, RO, 0);
    omode(ACT_SET, RO, 20);
    omode(ACT_HOLD, RO, 20);
    omode(ACT_CLEAR, RO, 0);
    omode(ACT_TOGGLE, RO, 10);
    omode(ACT_PWM0, RO, 6);
    omode(ACT_PWM1, RO, 14);
    omode(ACT_PWM1, RO | POL, 6);
    wr(OFS_CHVALUE, 32'hc);
    omode(ACT_PWM0, RO, 20);
    wr(OFS_CHVALUE, 32'h0);
    omode(ACT_PWM0, RO, 0);
    // shadowed compare value only moves on an update
    wr(OFS_CTRL, cfg(ACT_PWM0, DIR_OUTPUT, 4'h0, 2'h0, RO | CPEN));
    wr(OFS_CHVALUE, 32'h3);
    wr(OFS_EVGEN, 32'h1);
    omode(ACT_PWM0, RO | CPEN, 6);
    wr(OFS_CTRL, cfg(ACT_PWM0, DIR_OUTPUT, 4'h0, 2'h0, RO | CPEN | UBLK));
    wr(OFS_CHVALUE, 32'h6);
    omode(ACT_PWM0, RO | CPEN | UBLK, 6);
    omode(ACT_PWM0, RO | CPEN, 12);
    wr(OFS_CTRL, cfg(ACT_HOLD, DIR_OUTPUT, 4'h0, 2'h0, RUN | IEN));
    wr(OFS_STATUS, 32'h0);
    cyc(12);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rv & 32'h2, 32'h2);
    chk(channel_irq, 1);
    // capture: freeze the counter so the stored value is known
    wr(OFS_CTRL, 32'h0);
    apb(1'b0, OFS_COUNT, 32'h0);
    cval = rv;
    cap(cfg(ACT_HOLD, DIR_OWN_IN, 4'h0, 2'h0, IEN), 0, 3, 32'h2);
    chk(channel_irq, 1);
    rdc(OFS_CHVALUE, cval);
    wr(OFS_CHVALUE, 32'h55);
    rdc(OFS_CHVALUE, cval);
    u_sct_pin_model.pulse(0, 3);
    cyc(8);
    rdc(OFS_STATUS, 32'h202);
    wr(OFS_STATUS, 32'h0);
    cyc(2);
    chk(channel_irq, 0);
    wr(OFS_CTRL, cfg(ACT_HOLD, DIR_OWN_IN, 4'h0, 2'h0, POL));
    u_sct_pin_model.level(0, 1'b1);
    cyc(8);
    rdc(OFS_STATUS, 32'h0);
    u_sct_pin_model.level(0, 1'b0);
    cyc(8);
    rdc(OFS_STATUS, 32'h2);
    cap(cfg(ACT_HOLD, DIR_OWN_IN, 4'h0, 2'h0, PCOMP), 0, 3, 32'h202);
    cap(cfg(ACT_HOLD, DIR_OWN_IN, 4'h0, 2'h1, 8'h00), 0, 3, 32'h0);
    u_sct_pin_model.pulse(0, 3);
    cyc(8);
    rdc(OFS_STATUS, 32'h2);
    cap(cfg(ACT_HOLD, DIR_OWN_IN, 4'h3, 2'h0, 8'h00), 0, 2, 32'h0);
    cap(cfg(ACT_HOLD, DIR_OWN_IN, 4'h3, 2'h0, 8'h00), 0, 8, 32'h2);
    cap(cfg(ACT_HOLD, DIR_OTHER_IN, 4'h0, 2'h0, 8'h00), 0, 3, 32'h0);
    cap(cfg(ACT_HOLD, DIR_OTHER_IN, 4'h0, 2'h0, 8'h00), 1, 3, 32'h2);
    cap(cfg(ACT_HOLD, DIR_TRIGGER, 4'h0, 2'h0, 8'h00), 2, 3, 32'h2);
    // software channel event, then the same flag with the interrupt masked
    wr(OFS_CTRL, cfg(ACT_HOLD, DIR_OUTPUT, 4'h0, 2'h0, IEN));
    wr(OFS_STATUS, 32'h0);
    wr(OFS_EVGEN, 32'h2);
    cyc(2);
    rdc(OFS_STATUS, 32'h2);
    chk(channel_irq, 1);
    wr(OFS_CTRL, 32'h0);
    cyc(2);
    chk(channel_irq, 0);
    conclude();
  end
endmodule
